/* hdl/blit_regs_pkg.sv */
// constants, state codes and helper functions for the block-transfer register bank
`default_nettype none
package blit_regs_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [19:0] OFS_DEST_ADDR = 20'h40024;
    localparam logic [19:0] OFS_SRC_PITCH = 20'h4002C;
    localparam logic [19:0] OFS_SRC_ADDR = 20'h40030;
    localparam logic [19:0] OFS_CTRL = 20'h40034;
    localparam logic [19:0] OFS_DIMS = 20'h40038;
    // ----------------------------------------------------------------
    // field positions, masks and reset values
    // ----------------------------------------------------------------
    localparam int ADDR_BITS = 26;
    localparam int CTL_SOLID_PAT = 31;
    localparam int CTL_XDIR = 30;
    localparam int CTL_MSRC_TRANS = 29;
    localparam int CTL_MPAT_TRANS = 28;
    localparam int CTL_SRC_INLINE = 27;
    localparam int CTL_DEPTH_LO = 24;
    localparam int CTL_ROP_LO = 16;
    localparam int HEIGHT_LO = 16;
    localparam logic [31:0] SRC_PITCH_MASK = 32'h00003FFF;
    localparam logic [31:0] ADDR_MASK = 32'h03FFFFFF;
    localparam logic [31:0] CTRL_MASK = 32'hFFFF3FFF;
    localparam logic [31:0] DIMS_MASK = 32'h1FFF1FFF;
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [25:0] QW_STEP = 26'h0000008;
    // ----------------------------------------------------------------
    // color depth codes and engine states
    // ----------------------------------------------------------------
    localparam logic [1:0] DEPTH_8 = 2'h0;
    localparam logic [1:0] DEPTH_16 = 2'h1;
    localparam logic [1:0] DEPTH_24 = 2'h2;
    typedef enum logic [7:0] {
        S_IDLE = 8'h01, S_SRC = 8'h02, S_FILL = 8'h04, S_SRCRD = 8'h08,
        S_DEC = 8'h10, S_DRD = 8'h20, S_WR = 8'h40, S_NEXT = 8'h80
    } state_e;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] bytes_per_pixel(input logic [1:0] depth);
        if (depth == DEPTH_16) return 2'h2;
        else if (depth == DEPTH_24) return 2'h3;
        else return 2'h1;
    endfunction
    function automatic logic [3:0] be_mask(input logic [1:0] bpp);
        if (bpp == 2'h3) return 4'h7;
        else if (bpp == 2'h2) return 4'h3;
        else return 4'h1;
    endfunction
    function automatic logic [25:0] add_pitch(input logic [25:0] a, input logic [13:0] p);
        return a + {{12{p[13]}}, p};
    endfunction
    function automatic logic [23:0] rop_apply(input logic [7:0] rop, input logic [23:0] p,
                                              input logic [23:0] s, input logic [23:0] d);
        logic [23:0] r;
        r = 24'h000000;
        for (int i = 0; i < 24; i++) begin
            r[i] = rop[{p[i], s[i], d[i]}];
        end
        return r;
    endfunction
endpackage
`default_nettype wire

/* hdl/blit_src_dst_rop.sv */
// block-transfer engine with source, control and destination working registers
`default_nettype none
module blit_src_dst_rop
    import blit_regs_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic LD_VALID,
    input wire logic [19:0] LD_ADDR,
    input wire logic [31:0] LD_DATA,
    output logic LD_READY,
    input wire logic RD_EN,
    input wire logic [19:0] RD_ADDR,
    output logic [31:0] RD_DATA,
    input wire logic MONO_SRC,
    input wire logic [63:0] PAT_BITS,
    input wire logic [23:0] PAT_FG,
    input wire logic [23:0] PAT_BG,
    input wire logic [23:0] SRC_FG,
    input wire logic [23:0] SRC_BG,
    input wire logic INL_VALID,
    input wire logic [31:0] INL_DATA,
    output logic INL_READY,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [25:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    output logic [3:0] MEM_BE,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    output logic BUSY
);
    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (ADDR_W != ADDR_BITS) begin : g_bad_addr_w
        $error("address width must be 26");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    state_e state;
    logic [13:0] src_pitch;
    logic [25:0] src_addr;
    logic [31:0] ctrl;
    logic [25:0] dst_addr;
    logic [12:0] width;
    logic [12:0] height;
    logic [12:0] x_cnt;
    logic [12:0] xoff;
    logic [12:0] line_cnt;
    logic [2:0] pix_x;
    logic [1:0] byte_idx;
    logic [63:0] qbuf;
    logic qv;
    logic qhalf;
    logic first_q;
    logic [5:0] bptr;
    logic [13:0] quads_left;
    logic [13:0] skip_cnt;
    logic mono;
    logic mono_bit;
    logic [23:0] pix_src;
    logic [23:0] pix_dst;
    logic mem_req;
    logic mem_we;
    logic [25:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [3:0] mem_be;
    logic [31:0] rd_data;
    logic [31:0] next_rd_data;

    // ----------------------------------------------------------------
    // decode and datapath
    // ----------------------------------------------------------------
    wire logic idle = (state == S_IDLE);
    wire logic ld_take = LD_VALID && idle;
    wire logic ld_pitch = ld_take && (LD_ADDR == OFS_SRC_PITCH);
    wire logic ld_src = ld_take && (LD_ADDR == OFS_SRC_ADDR);
    wire logic ld_ctrl = ld_take && (LD_ADDR == OFS_CTRL);
    wire logic ld_dims = ld_take && (LD_ADDR == OFS_DIMS);
    wire logic ld_dst = ld_take && (LD_ADDR == OFS_DEST_ADDR);
    wire logic [1:0] depth = ctrl[CTL_DEPTH_LO +: 2];
    wire logic [1:0] bpp = bytes_per_pixel(depth);
    wire logic [12:0] bpp13 = {11'h000, bpp};
    wire logic src_inline = ctrl[CTL_SRC_INLINE];
    wire logic xdir = ctrl[CTL_XDIR];
    wire logic solid = ctrl[CTL_SOLID_PAT];
    wire logic msrc_tr = ctrl[CTL_MSRC_TRANS];
    wire logic mpat_tr = ctrl[CTL_MPAT_TRANS];
    wire logic [7:0] rop = ctrl[CTL_ROP_LO +: 8];
    wire logic [12:0] xstart = xdir ? (width - bpp13) : 13'h0000;
    wire logic line_last_pix = (x_cnt + bpp13) >= width;
    wire logic line_last = (line_cnt + 13'h0001) == height;
    wire logic line_end = (state == S_NEXT) && line_last_pix;
    wire logic fb_color = !src_inline && !mono;
    wire logic need_q = mono || src_inline;
    wire logic pat_bit = solid ? 1'b0 : PAT_BITS[{line_cnt[2:0], pix_x}];
    wire logic [23:0] pat_op = pat_bit ? PAT_FG : PAT_BG;
    wire logic [23:0] src_op = mono ? (mono_bit ? SRC_FG : SRC_BG) : pix_src;
    wire logic skip_src = mono && !mono_bit && msrc_tr;
    wire logic skip_pat = !pat_bit && mpat_tr;
    wire logic keep = !skip_src && !skip_pat;
    wire logic [23:0] result = rop_apply(rop, pat_op, src_op, pix_dst);
    wire logic [25:0] pix_dst_addr = dst_addr + {13'h0000, xoff};
    wire logic [25:0] pix_src_addr = src_addr + {13'h0000, xoff};
    wire logic [7:0] q_byte = qbuf[{bptr[5:3], 3'h0} +: 8];
    wire logic q_bit = qbuf[{bptr[5:3], ~bptr[2:0]}];
    wire logic [13:0] width14 = {1'b0, width};
    wire logic [13:0] pad = (src_pitch > width14) ? (src_pitch - width14) : 14'h0000;
    wire logic fill_zero = mono && (quads_left == 14'h0000);
    wire logic fill_word = src_inline ? INL_VALID : (mem_req && MEM_ACK);
    wire logic [31:0] fill_data = src_inline ? INL_DATA : MEM_RDATA;
    wire logic fill_done = (state == S_FILL) && !fill_zero && fill_word && qhalf;
    wire logic fb_step = fill_done && !src_inline;

    // ----------------------------------------------------------------
    // register bank
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            src_pitch <= REG_RESET[13:0];
            ctrl <= REG_RESET;
            width <= REG_RESET[12:0];
            height <= REG_RESET[12:0];
        end else begin
            if (ld_pitch) src_pitch <= LD_DATA[13:0];
            if (ld_ctrl) ctrl <= LD_DATA & CTRL_MASK;
            if (ld_dims) width <= LD_DATA[12:0];
            if (ld_dims) height <= LD_DATA[HEIGHT_LO +: 13];
        end
    end

    // working address registers move while the engine runs
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            src_addr <= REG_RESET[25:0];
            dst_addr <= REG_RESET[25:0];
        end else begin
            if (ld_src) src_addr <= LD_DATA[25:0];
            else if (line_end && fb_color) src_addr <= add_pitch(src_addr, src_pitch);
            else if (fb_step) src_addr <= src_addr + QW_STEP;
            if (ld_dst) dst_addr <= LD_DATA[25:0];
            else if (line_end) dst_addr <= add_pitch(dst_addr, ctrl[13:0]);
        end
    end

    // unmapped offsets read as zero; reserved bits stored as zero
    always_comb begin
        next_rd_data = 32'h00000000;
        if (RD_ADDR == OFS_SRC_PITCH) next_rd_data = {18'h00000, src_pitch};
        else if (RD_ADDR == OFS_SRC_ADDR) next_rd_data = {6'h00, src_addr};
        else if (RD_ADDR == OFS_CTRL) next_rd_data = ctrl;
        else if (RD_ADDR == OFS_DEST_ADDR) next_rd_data = {6'h00, dst_addr};
        else if (RD_ADDR == OFS_DIMS) next_rd_data = {3'h0, height, 3'h0, width};
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) rd_data <= 32'h00000000;
        else if (RD_EN) rd_data <= next_rd_data;
    end

    // ----------------------------------------------------------------
    // engine
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state <= S_IDLE;
            x_cnt <= 13'h0000;
            xoff <= 13'h0000;
            line_cnt <= 13'h0000;
            pix_x <= 3'h0;
            byte_idx <= 2'h0;
            qbuf <= 64'h0000000000000000;
            qv <= 1'b0;
            qhalf <= 1'b0;
            first_q <= 1'b0;
            bptr <= 6'h00;
            quads_left <= 14'h0000;
            skip_cnt <= 14'h0000;
            mono <= 1'b0;
            mono_bit <= 1'b0;
            pix_src <= 24'h000000;
            pix_dst <= 24'h000000;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 26'h0000000;
            mem_wdata <= 32'h00000000;
            mem_be <= 4'h0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (ld_dst && (width != 13'h0000) && (height != 13'h0000)) begin
                        x_cnt <= 13'h0000;
                        xoff <= xstart;
                        line_cnt <= 13'h0000;
                        pix_x <= 3'h0;
                        byte_idx <= 2'h0;
                        qv <= 1'b0;
                        qhalf <= 1'b0;
                        first_q <= 1'b1;
                        mono <= MONO_SRC;
                        quads_left <= src_pitch;
                        skip_cnt <= 14'h0000;
                        state <= S_SRC;
                    end
                end
                S_SRC: begin
                    if (!qv && need_q) begin
                        state <= S_FILL;
                    end else if (mono) begin
                        mono_bit <= q_bit;
                        bptr <= bptr + 6'h01;
                        if (bptr == 6'h3F) qv <= 1'b0;
                        state <= S_DEC;
                    end else if (src_inline) begin
                        bptr <= bptr + 6'h08;
                        if (bptr[5:3] == 3'h7) qv <= 1'b0;
                        if (skip_cnt != 14'h0000) begin
                            skip_cnt <= skip_cnt - 14'h0001;
                        end else begin
                            pix_src[{byte_idx, 3'h0} +: 8] <= q_byte;
                            if (byte_idx == (bpp - 2'h1)) begin
                                byte_idx <= 2'h0;
                                state <= S_DEC;
                            end else begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end else begin
                        state <= S_SRCRD;
                    end
                end
                S_FILL: begin
                    if (fill_zero) begin
                        qbuf <= 64'h0000000000000000;
                        qv <= 1'b1;
                        bptr <= 6'h00;
                        state <= S_SRC;
                    end else if (!src_inline && !mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_be <= 4'hF;
                        mem_addr <= {src_addr[25:3], qhalf, 2'h0};
                    end else if (fill_word) begin
                        mem_req <= 1'b0;
                        // words pair into one quadword, low word first
                        if (!qhalf) begin
                            qbuf[31:0] <= fill_data;
                            qhalf <= 1'b1;
                        end else begin
                            qbuf[63:32] <= fill_data;
                            qhalf <= 1'b0;
                            qv <= 1'b1;
                            first_q <= 1'b0;
                            bptr <= first_q ? {src_addr[2:0], 3'h0} : 6'h00;
                            if (mono) quads_left <= quads_left - 14'h0001;
                            state <= S_SRC;
                        end
                    end
                end
                S_SRCRD: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_be <= be_mask(bpp);
                        mem_addr <= pix_src_addr;
                    end else if (MEM_ACK) begin
                        mem_req <= 1'b0;
                        pix_src <= MEM_RDATA[23:0];
                        state <= S_DEC;
                    end
                end
                S_DEC: begin
                    state <= keep ? S_DRD : S_NEXT;
                end
                S_DRD: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_be <= be_mask(bpp);
                        mem_addr <= pix_dst_addr;
                    end else if (MEM_ACK) begin
                        mem_req <= 1'b0;
                        pix_dst <= MEM_RDATA[23:0];
                        state <= S_WR;
                    end
                end
                S_WR: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_be <= be_mask(bpp);
                        mem_addr <= pix_dst_addr;
                        mem_wdata <= {8'h00, result};
                    end else if (MEM_ACK) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        state <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    if (line_last_pix) begin
                        x_cnt <= 13'h0000;
                        xoff <= xstart;
                        pix_x <= 3'h0;
                        line_cnt <= line_cnt + 13'h0001;
                        if (src_inline && !mono) skip_cnt <= pad;
                        state <= line_last ? S_IDLE : S_SRC;
                    end else begin
                        x_cnt <= x_cnt + bpp13;
                        xoff <= xdir ? (xoff - bpp13) : (xoff + bpp13);
                        pix_x <= pix_x + 3'h1;
                        state <= S_SRC;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign LD_READY = idle;
    assign INL_READY = (state == S_FILL) && src_inline && !fill_zero;
    assign RD_DATA = rd_data;
    assign MEM_REQ = mem_req;
    assign MEM_WE = mem_we;
    assign MEM_ADDR = mem_addr;
    assign MEM_WDATA = mem_wdata;
    assign MEM_BE = mem_be;
    assign BUSY = !idle;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_line_end;
        (state == S_NEXT) && line_last_pix;
    endsequence
    sequence s_start;
        ld_dst && (width != 13'h0000) && (height != 13'h0000);
    endsequence
    property p_start;
        @(posedge CLK_SYS) disable iff (!RST_N) s_start |=> (state == S_SRC) && BUSY && !LD_READY;
    endproperty
    a_start: assert property (p_start) else $error("destination load did not start engine");
    property p_dst_pitch;
        @(posedge CLK_SYS) disable iff (!RST_N)
            s_line_end |=> dst_addr == add_pitch($past(dst_addr), $past(ctrl[13:0]));
    endproperty
    a_dst_pitch: assert property (p_dst_pitch) else $error("destination pitch not applied");
    property p_src_pitch;
        @(posedge CLK_SYS) disable iff (!RST_N)
            s_line_end ##0 fb_color |=> src_addr == add_pitch($past(src_addr), $past(src_pitch));
    endproperty
    a_src_pitch: assert property (p_src_pitch) else $error("source pitch not applied");
    property p_xdir;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (state == S_NEXT) && !line_last_pix && xdir |=> xoff == $past(xoff) - $past(bpp13);
    endproperty
    a_xdir: assert property (p_xdir) else $error("right to left step wrong");
    property p_src_trans;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (state == S_DEC) && mono && !mono_bit && msrc_tr |=> (state == S_NEXT) ##1 !MEM_WE;
    endproperty
    a_src_trans: assert property (p_src_trans) else $error("transparent source pixel written");
    property p_pat_trans;
        @(posedge CLK_SYS) disable iff (!RST_N) (state == S_DEC) && !pat_bit && mpat_tr |=> state == S_NEXT;
    endproperty
    a_pat_trans: assert property (p_pat_trans) else $error("transparent pattern pixel written");
    property p_solid;
        @(posedge CLK_SYS) disable iff (!RST_N) (state == S_DEC) && solid |-> (pat_op == PAT_BG) && !pat_bit;
    endproperty
    a_solid: assert property (p_solid) else $error("solid pattern not background");
    property p_inline_no_mem;
        @(posedge CLK_SYS) disable iff (!RST_N) (state == S_FILL) && src_inline |-> !MEM_REQ;
    endproperty
    a_inline_no_mem: assert property (p_inline_no_mem) else $error("memory read for inline source");
    property p_rop;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (state == S_WR) && !mem_req |=> MEM_REQ && MEM_WE && (MEM_WDATA[23:0] == $past(result));
    endproperty
    a_rop: assert property (p_rop) else $error("write data is not the raster result");
    property p_depth16;
        @(posedge CLK_SYS) disable iff (!RST_N) MEM_REQ && MEM_WE && (depth == DEPTH_16) |-> MEM_BE == 4'h3;
    endproperty
    a_depth16: assert property (p_depth16) else $error("16 bit pixel byte enables wrong");
    property p_quad_zero;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (state == S_FILL) && fill_zero |=> (qbuf == 64'h0000000000000000) && qv && !MEM_REQ;
    endproperty
    a_quad_zero: assert property (p_quad_zero) else $error("fetch beyond quadword count");
endmodule // blit_src_dst_rop
`default_nettype wire

/* testbench/fb_mem_model.sv */
// frame buffer model: reads answered at once, writes after three idle cycles
`default_nettype none
module fb_mem_model (input wire logic clk, rst_n, req, we, input wire logic [25:0] addr,
    input wire logic [31:0] wdata, input wire logic [3:0] be, output logic ack, output logic [31:0] rdata, last_wd,
    output logic [3:0] last_be, output logic [25:0] first_wa, last_wa, output int wcount);
    timeunit 1ns / 1ps;
    logic [3:0] cnt;
    wire logic answer = req && !ack && cnt == (we ? 4'h3 : 4'h0);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ack, cnt, rdata, wcount} <= '0;
        end else begin
            ack <= answer;
            cnt <= (req && !answer && !ack) ? cnt + 4'h1 : 4'h0;
            rdata <= answer ? {6'h00, addr} : ~rdata; // never holds stale data
            if (answer && we) begin
                wcount <= wcount + 1;
                {last_wa, last_wd, last_be} <= {addr, wdata, be};
                if (wcount == 0) first_wa <= addr;
            end
        end
    end
endmodule // fb_mem_model
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the block-transfer engine
`default_nettype none
module tb_top;
    timeunit 1ns / 1ps;
    import blit_regs_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ld_v = 1'b0, rd_en = 1'b0, req, we, ack, busy;
    logic [19:0] ld_a = 20'h0, rd_a = 20'h0;
    logic [31:0] ld_d = 32'h0, rd_d, wd, rdat, lwd;
    logic [25:0] ma, fwa, lwa;
    logic [23:0] pat_bg = 24'h0, pat_fg = 24'h0;
    logic [63:0] pat = 64'h0;
    logic [3:0] be, lbe;
    logic ld_rdy, inl_rdy, inl_v = 1'b0, mono = 1'b0;
    logic [31:0] inl_d = 32'h0;
    int wcount, fail_count = 0, check_count = 0;
    always #4 clk = ~clk;
    blit_src_dst_rop i_blit_src_dst_rop (.CLK_SYS(clk), .RST_N(rst_n), .LD_VALID(ld_v), .LD_ADDR(ld_a),
        .LD_DATA(ld_d), .LD_READY(ld_rdy), .RD_EN(rd_en), .RD_ADDR(rd_a), .RD_DATA(rd_d), .MONO_SRC(mono),
        .PAT_BITS(pat), .PAT_FG(pat_fg), .PAT_BG(pat_bg), .SRC_FG(pat_fg), .SRC_BG(pat_bg),
        .INL_VALID(inl_v), .INL_DATA(inl_d), .INL_READY(inl_rdy), .MEM_REQ(req), .MEM_WE(we), .MEM_ADDR(ma),
        .MEM_WDATA(wd), .MEM_BE(be), .MEM_ACK(ack), .MEM_RDATA(rdat), .BUSY(busy));
    fb_mem_model i_fb_mem_model (.clk(clk), .rst_n(rst_n), .req(req), .we(we), .addr(ma), .wdata(wd), .be(be),
        .ack(ack), .rdata(rdat), .last_wd(lwd), .last_be(lbe), .first_wa(fwa), .last_wa(lwa), .wcount(wcount));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        fail_count += int'(seen !== exp);
        if (seen !== exp) $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic ld(input logic [19:0] a, input logic [31:0] d);
        {ld_a, ld_d, ld_v} = {a, d, 1'b1};
        @(negedge clk);
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        {rd_a, rd_en} = {a, 1'b1};
        @(negedge clk);
        chk(rd_d, exp);
    endtask
    // loads held back to back; destination last since it starts the engine
    task automatic run(input logic [31:0] ctrl, input logic [31:0] dims, input logic [31:0] src);
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        ld(OFS_SRC_PITCH, 32'hFFFFC010);
        ld(OFS_SRC_ADDR, src);
        ld(OFS_CTRL, ctrl);
        ld(OFS_DIMS, dims);
        ld(OFS_DEST_ADDR, 32'h00002000);
        ld_v = 1'b0;
        chk({30'h0, ld_rdy, busy}, 32'h1);
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
        chk({30'h0, ld_rdy, busy}, 32'h2);
        if (busy !== 1'b0) finish_test();
    endtask
    // one doubleword offered until the engine takes it
    task automatic feed(input logic [31:0] w);
        {inl_d, inl_v} = {w, 1'b1};
        for (int n = 0; n < 200 && inl_rdy !== 1'b1; n++) @(negedge clk);
        chk({31'h0, inl_rdy}, 32'h1);
        @(negedge clk);
    endtask
    task automatic t_trans();
        run(32'h140F0010, 32'h00010002, 32'h0);
        chk(32'(wcount), 32'h0);
    endtask
    // pitch 16, width 4: twelve bytes skipped between lines, six doublewords in all
    task automatic t_inline();
        fork
            run(32'h0CCC0040, 32'h00020004, 32'h0);
            begin
                for (int k = 0; k < 6; k++) feed({8'(4 * k + 3), 8'(4 * k + 2), 8'(4 * k + 1), 8'(4 * k)});
                inl_v = 1'b0;
            end
        join
        chk(32'(wcount), 32'h8);
        chk(32'(lwa), 32'h00002043);
        chk(32'(lwd[7:0]), 32'h00000013);
        chk(32'(lbe), 32'h1);
    endtask
    // first byte at offset 4 holds 8'h04: only pixel 5 has a set source bit
    task automatic t_mono();
        {mono, pat, pat_fg} = {1'b1, 64'h20, 24'h0000C3};
        run(32'h24F00000, 32'h00010008, 32'hFC000004);
        chk(32'(wcount), 32'h1);
        chk(32'(fwa), 32'h00002005);
        chk(lwd, 32'h000000C3);
        rd(OFS_SRC_ADDR, 32'h0000000C);
        mono = 1'b0;
    endtask
    task automatic t_draw();
        pat_bg = 24'h00005A;
        run(32'hC40F3FF0, 32'h00020002, 32'h0);
        chk(32'(wcount), 32'h4);
        chk(32'(fwa), 32'h00002001);
        chk(32'(lwa), 32'h00001FF0);
        chk(32'(lwd[7:0]), 32'h000000A5);
        rd(OFS_SRC_PITCH, 32'h00000010);
        rd(OFS_CTRL, 32'hC40F3FF0);
        rd(20'h40000, 32'h00000000);
    endtask
    initial begin
        t_trans();
        t_draw();
        t_inline();
        t_mono();
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
